// ==== rtl/emr_pkg.sv ====
package emr_pkg;

   localparam int SAMPLE_W  = 24;
   localparam int CHANS     = 8;
   localparam int EMB_CHANS = 16;
   localparam int GROUPS    = 4;
   localparam int GRP_CHANS = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int ACC_W     = 27;
   localparam int PROD_W    = 52;
   localparam int MON_W     = 48;

   ////////////////////////////////////////////////////////////////////////
   // gain in whole dB: linear = mant[k%6] * 2^(k/6) / 2^24, k = dB + 72
   localparam logic signed [7:0] GAIN_MIN     = -8'sd70;
   localparam logic signed [7:0] GAIN_MAX     = 8'sd12;
   localparam logic signed [7:0] GAIN_DEFAULT = 8'sd0;
   localparam logic [7:0]        GAIN_OFFSET  = 8'h48;
   localparam logic [7:0]        DB_STEP      = 8'h06;
   localparam int                GAIN_FRAC    = 24;
   localparam logic [13:0] GAIN_MANT [0:5] =
      '{14'h1000, 14'h11f4, 14'h1425, 14'h169a, 14'h195c, 14'h1c74};

   // monitor volume in percent; divide by 100 as multiply then shift
   localparam logic [6:0]  VOL_MAX     = 7'h64;
   localparam logic [15:0] VOL_RECIP   = 16'ha3d7;
   localparam int          VOL_SHIFT   = 22;

   localparam logic signed [23:0] SAMPLE_MAX = 24'sh7fffff;
   localparam logic signed [23:0] SAMPLE_MIN = -24'sh800000;

   // peak thresholds: clipping, then 2/4/6/8/10 dB below full scale
   localparam logic [23:0] PEAK_THR [0:5] =
      '{24'h7fffff, 24'h65ac8a, 24'h50c333, 24'h4026e5, 24'h32f52b, 24'h287a28};
   // 0 VU at -20 dBFS, -20 VU at -40 dBFS
   localparam logic [23:0] VU_ZERO_THR  = 24'h0ccccd;
   localparam logic [23:0] VU_MINUS_THR = 24'h01478e;

   localparam logic [7:0] OUT_EN_MUX4  = 8'h0f;
   localparam logic [7:0] OUT_EN_DEMUX = 8'hff;
   localparam logic [7:0] OUT_EN_MUX8  = 8'h00;

   typedef enum logic [1:0] {
      mode_mux4  = 2'b00,
      mode_mux8  = 2'b01,
      mode_demux = 2'b10
   } emr_mode_t;

   typedef enum logic [2:0] {
      st_no_audio = 3'b000,
      st_group1   = 3'b001,
      st_group2   = 3'b010,
      st_group3   = 3'b011,
      st_group4   = 3'b100,
      st_off      = 3'b101
   } emr_status_t;

   typedef enum logic [1:0] {
      vu_low  = 2'b00,
      vu_mid  = 2'b01,
      vu_high = 2'b10
   } emr_vu_t;

   typedef struct packed {
      logic [GROUPS-1:0]                   present;
      logic [EMB_CHANS-1:0][SAMPLE_W-1:0] chan;
   } emr_frame_t;

   localparam int FRAME_W = $bits(emr_frame_t);

   function automatic logic signed [23:0] emr_sat(input logic signed [PROD_W-1:0] v);
      if (v > PROD_W'(SAMPLE_MAX))
         return SAMPLE_MAX;
      else if (v < PROD_W'(SAMPLE_MIN))
         return SAMPLE_MIN;
      else
         return v[23:0];
   endfunction

endpackage

// ==== rtl/emr_fifo.sv ====
module emr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
   logic             push, pop;

   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign in_ready  = (wr_reg[AW] == rd_reg[AW]) | (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
   assign out_valid = wr_reg != rd_reg;
   assign out_data  = mem[rd_reg[AW-1:0]];

   always_comb
   begin
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wr_reg[AW-1:0]] <= in_data;
   end

endmodule // emr_fifo

// ==== rtl/emr_mixer_router.sv ====
// Overview of operation
// [R1] port modes: four in/four out, eight in, eight out demux
// [R2] primary group picks any of four groups, never off
// [R3] secondary group picks any of four groups, or off
// [R4] status per group: no audio or group number; secondary may report off
// [R5] mixer one takes channels 1-4, mixer two channels 5-8
// [R6] per-channel gain settable in dB from -70 to +12
// [R7] each input channel routed to the output channels in its route mask
// [R8] tie on channel 1 or 2 shares gain; 3 and 4 likewise
// [R9] tie on channel 5 or 6 shares gain; 7 and 8 likewise
// [R10] invert flips the polarity of a channel's samples
// [R11] peak and VU indication for every output channel
// [R12] peak raised when level reaches or exceeds headroom threshold
// [R13] headroom selectable as clipping, 2, 4, 6, 8 or 10 dB
// [R14] VU band: above 0 VU, above -20 VU, below -20 VU
// [R15] one of eight pairs 1/2 to 15/16 sent to the headphone monitor
// [R16] monitor volume 0 to 100 percent, default 100
// [R17] one of eight pairs 1/2 to 15/16 sent to HDMI
// [R18] sixteen embedded channels of 24 bits passed, two groups assignable
// [R19] 24-bit samples at 48 kHz
// [R20] gain and mix saturate to 24-bit range; gains default to 0 dB
module emr_mixer_router (
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst,
   input  wire logic                                   in_valid,
   input  wire emr_pkg::emr_frame_t                    in_frame,
   output logic                                        in_ready,
   input  wire emr_pkg::emr_mode_t                     audio_mode,
   input  wire logic [1:0]                             group_a_sel,
   input  wire logic [1:0]                             group_b_sel,
   input  wire logic                                   group_b_off,
   input  wire logic [7:0]                             gain_wr,
   input  wire logic signed [7:0]                      gain_wdata,
   input  wire logic [7:0]                             tie,
   input  wire logic [7:0]                             invert,
   input  wire logic [7:0][7:0]                        output_channel_route,
   input  wire logic [2:0]                             peak_headroom,
   input  wire logic [2:0]                             mon_sel,
   input  wire logic                                   vol_wr,
   input  wire logic [6:0]                             vol_wdata,
   input  wire logic [2:0]                             hdmi_sel,
   input  wire logic                                   out_ready,
   output logic                                        out_valid,
   output logic [7:0]                                  out_enable,
   output logic [7:0][23:0]                            out_chan,
   output logic [15:0][23:0]                           embed_out,
   output logic [23:0]                                 mon_left,
   output logic [23:0]                                 mon_right,
   output logic [23:0]                                 hdmi_left,
   output logic [23:0]                                 hdmi_right,
   output logic [7:0]                                  peak,
   output logic [7:0][1:0]                             vu_band,
   output emr_pkg::emr_status_t                        group_a_status,
   output emr_pkg::emr_status_t                        group_b_status
);

   ////////////////////////////////////////////////////////////////////////
   // input buffer
   localparam int        FW = $clog2(emr_pkg::FIFO_DEPTH) + 1;
   logic                 f_valid, advance, pop, take;
   logic [FW-1:0]        fill_reg, fill_next;
   emr_pkg::emr_frame_t  f_frame;
   logic [emr_pkg::FRAME_W-1:0] f_data;

   emr_fifo #(
      .WIDTH (emr_pkg::FRAME_W),
      .DEPTH (emr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (take),
      .in_data   (in_frame),
      .in_ready  (),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (advance)
   );

   assign f_frame = emr_pkg::emr_frame_t'(f_data);
   assign advance = ~out_valid | out_ready;
   assign pop     = f_valid & advance;
   assign take    = in_valid & in_ready;

   // fill count lets the registered ready drop on the edge that fills the buffer
   always_comb
   begin
      fill_next = fill_reg + FW'(take) - FW'(pop);
   end

   ////////////////////////////////////////////////////////////////////////
   // settings
   logic signed [7:0] gain_reg [0:7];
   logic signed [7:0] gain_next [0:7];
   logic signed [7:0] gain_clamped;
   logic [6:0]        vol_reg, vol_next;

   always_comb
   begin
      gain_clamped = gain_wdata;
      if (gain_wdata < emr_pkg::GAIN_MIN)
         gain_clamped = emr_pkg::GAIN_MIN; // [R6]
      else if (gain_wdata > emr_pkg::GAIN_MAX)
         gain_clamped = emr_pkg::GAIN_MAX; // [R6]
      for (int i = 0; i < emr_pkg::CHANS; i++)
         gain_next[i] = gain_wr[i] ? gain_clamped : gain_reg[i];
      vol_next = vol_reg;
      if (vol_wr)
         vol_next = (vol_wdata > emr_pkg::VOL_MAX) ? emr_pkg::VOL_MAX : vol_wdata; // [R16]
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < emr_pkg::CHANS; i++)
            gain_reg[i] <= emr_pkg::GAIN_DEFAULT; // [R20]
         vol_reg <= emr_pkg::VOL_MAX; // [R16]
      end
      else
      begin
         gain_reg <= gain_next;
         vol_reg  <= vol_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage 1: group select, invert, gain
   logic signed [23:0] g_next [0:7];
   logic signed [23:0] g_reg [0:7];

   genvar gi;
   generate
      for (gi = 0; gi < emr_pkg::CHANS; gi++)
      begin : g_chan
         localparam int PAIR = (gi / 2) * 2;
         logic signed [23:0]            src, inv;
         logic signed [7:0]             g_db;
         logic [7:0]                    k, ex, rm;
         logic signed [emr_pkg::PROD_W-1:0] prod, scaled;
         logic [1:0]                    grp;
         logic                          on;

         if (gi < emr_pkg::GRP_CHANS)
         begin : g_a
            assign grp = group_a_sel; // [R2]
            assign on  = 1'b1; // [R5]
         end
         else
         begin : g_b
            assign grp = group_b_sel;
            assign on  = ~group_b_off; // [R3] [R5]
         end

         assign src = (on & f_frame.present[grp])
                    ? f_frame.chan[{grp, 2'(gi % emr_pkg::GRP_CHANS)}] : '0;
         assign inv = ~invert[gi] ? src :
                      (src == emr_pkg::SAMPLE_MIN) ? emr_pkg::SAMPLE_MAX : -src; // [R10]
         assign g_db = (tie[PAIR] | tie[PAIR+1]) ? gain_reg[PAIR] : gain_reg[gi]; // [R8] [R9]
         assign k    = 8'(g_db) + emr_pkg::GAIN_OFFSET; // [R6]
         assign ex   = k / emr_pkg::DB_STEP;
         assign rm   = k % emr_pkg::DB_STEP;
         assign prod = emr_pkg::PROD_W'(inv)
                     * $signed({38'h0, emr_pkg::GAIN_MANT[rm[2:0]]});
         assign scaled = (prod <<< ex) >>> emr_pkg::GAIN_FRAC;
         assign g_next[gi] = emr_pkg::emr_sat(scaled); // [R20]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // stage 2: routing and mixing, metering
   logic signed [23:0] mix [0:7];
   logic [7:0]         en_mode;

   always_comb
   begin
      case (audio_mode) // [R1]
         emr_pkg::mode_mux4:  en_mode = emr_pkg::OUT_EN_MUX4;
         emr_pkg::mode_demux: en_mode = emr_pkg::OUT_EN_DEMUX;
         default:             en_mode = emr_pkg::OUT_EN_MUX8;
      endcase
   end

   generate
      for (gi = 0; gi < emr_pkg::CHANS; gi++)
      begin : g_out
         logic signed [emr_pkg::ACC_W-1:0] acc;
         always_comb
         begin
            acc = '0;
            for (int i = 0; i < emr_pkg::CHANS; i++)
               if (output_channel_route[i][gi])
                  acc = acc + emr_pkg::ACC_W'(g_reg[i]); // [R7]
         end
         assign mix[gi] = en_mode[gi] ? emr_pkg::emr_sat(emr_pkg::PROD_W'(acc)) : '0; // [R20]
      end
   endgenerate

   logic [7:0]       peak_next;
   logic [7:0][1:0]  vu_next;
   logic [23:0]      mag;
   logic [23:0]      thr;

   always_comb
   begin
      thr = (peak_headroom > 3'h5) ? emr_pkg::PEAK_THR[0]
          : emr_pkg::PEAK_THR[peak_headroom]; // [R13]
      peak_next = '0;
      vu_next   = '0;
      mag       = '0;
      for (int j = 0; j < emr_pkg::CHANS; j++)
      begin
         mag = mix[j][23] ? 24'(-mix[j]) : 24'(mix[j]); // [R11]
         if (mix[j] == emr_pkg::SAMPLE_MIN)
            mag = emr_pkg::SAMPLE_MAX;
         peak_next[j] = (mag >= thr); // [R12]
         if (mag > emr_pkg::VU_ZERO_THR)
            vu_next[j] = emr_pkg::vu_high; // [R14]
         else if (mag > emr_pkg::VU_MINUS_THR)
            vu_next[j] = emr_pkg::vu_mid; // [R14]
         else
            vu_next[j] = emr_pkg::vu_low; // [R14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pair selection, monitor volume, group status
   logic [15:0][23:0]    emb_next;
   logic signed [23:0]   ml_next, mr_next, hl_next, hr_next;
   logic signed [emr_pkg::MON_W-1:0] ml_w, mr_w;
   emr_pkg::emr_status_t sa_next, sb_next;

   always_comb
   begin
      emb_next = f_frame.chan; // [R18] [R19]
      ml_w = emr_pkg::MON_W'($signed(f_frame.chan[{mon_sel, 1'b0}]))
           * $signed({41'h0, vol_reg}) * $signed({32'h0, emr_pkg::VOL_RECIP}); // [R15] [R16]
      mr_w = emr_pkg::MON_W'($signed(f_frame.chan[{mon_sel, 1'b1}]))
           * $signed({41'h0, vol_reg}) * $signed({32'h0, emr_pkg::VOL_RECIP}); // [R15] [R16]
      ml_next = 24'(ml_w >>> emr_pkg::VOL_SHIFT);
      mr_next = 24'(mr_w >>> emr_pkg::VOL_SHIFT);
      hl_next = f_frame.chan[{hdmi_sel, 1'b0}]; // [R17]
      hr_next = f_frame.chan[{hdmi_sel, 1'b1}]; // [R17]
      sa_next = f_frame.present[group_a_sel]
              ? emr_pkg::emr_status_t'({1'b0, group_a_sel} + 3'h1)
              : emr_pkg::st_no_audio; // [R4]
      if (group_b_off)
         sb_next = emr_pkg::st_off; // [R4]
      else if (f_frame.present[group_b_sel])
         sb_next = emr_pkg::emr_status_t'({1'b0, group_b_sel} + 3'h1); // [R4]
      else
         sb_next = emr_pkg::st_no_audio;
   end

   ////////////////////////////////////////////////////////////////////////
   // pipeline registers
   logic s1_valid;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         in_ready       <= 1'b0;
         fill_reg       <= '0;
         s1_valid       <= 1'b0;
         out_valid      <= 1'b0;
         out_enable     <= '0;
         embed_out      <= '0;
         mon_left       <= '0;
         mon_right      <= '0;
         hdmi_left      <= '0;
         hdmi_right     <= '0;
         peak           <= '0;
         vu_band        <= '0;
         group_a_status <= emr_pkg::st_no_audio;
         group_b_status <= emr_pkg::st_no_audio;
         for (int i = 0; i < emr_pkg::CHANS; i++)
         begin
            g_reg[i]    <= '0;
            out_chan[i] <= '0;
         end
      end
      else
      begin
         in_ready   <= fill_next != FW'(emr_pkg::FIFO_DEPTH);
         fill_reg   <= fill_next;
         out_enable <= en_mode; // [R1]
         if (advance)
         begin
            s1_valid  <= pop;
            out_valid <= s1_valid;
            if (pop)
            begin
               g_reg          <= g_next;
               embed_out      <= emb_next;
               mon_left       <= ml_next;
               mon_right      <= mr_next;
               hdmi_left      <= hl_next;
               hdmi_right     <= hr_next;
               group_a_status <= sa_next;
               group_b_status <= sb_next;
            end
            if (s1_valid)
            begin
               for (int i = 0; i < emr_pkg::CHANS; i++)
                  out_chan[i] <= mix[i];
               peak    <= peak_next;
               vu_band <= vu_next;
            end
         end
      end
   end

endmodule // emr_mixer_router

// ==== sim/emr_mixer_router_assertions.sv ====
module emr_mixer_router_assertions (
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic                 in_ready,
   input wire emr_pkg::emr_mode_t   audio_mode,
   input wire logic                 group_b_off,
   input wire logic [2:0]           peak_headroom,
   input wire logic                 out_ready,
   input wire logic                 out_valid,
   input wire logic [7:0]           out_enable,
   input wire logic [7:0][23:0]     out_chan,
   input wire logic [7:0]           peak,
   input wire logic [7:0][1:0]      vu_band,
   input wire emr_pkg::emr_status_t group_a_status,
   input wire emr_pkg::emr_status_t group_b_status
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] mag(input logic [23:0] s);
      return s[23] ? -s : s;
   endfunction

   function automatic logic [7:0] pk(input logic [7:0][23:0] c, input logic [2:0] h);
      for (int i = 0; i < 8; i++)
         pk[i] = mag(c[i]) >= emr_pkg::PEAK_THR[(h > 3'h5) ? 3'h0 : h];
   endfunction

   function automatic logic [7:0][1:0] vu(input logic [7:0][23:0] c);
      for (int i = 0; i < 8; i++)
         vu[i] = (mag(c[i]) > emr_pkg::VU_ZERO_THR) ? 2'h2 :
                 (mag(c[i]) > emr_pkg::VU_MINUS_THR) ? 2'h1 : 2'h0;
   endfunction

   function automatic logic [7:0] en(input emr_pkg::emr_mode_t m);
      return (m == emr_pkg::mode_mux4) ? emr_pkg::OUT_EN_MUX4 :
             (m == emr_pkg::mode_demux) ? emr_pkg::OUT_EN_DEMUX : emr_pkg::OUT_EN_MUX8;
   endfunction

   sequence stalled;
      out_valid && !out_ready;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   ready_release_a: assert property ($fell(rst) |=> in_ready)
      else $error("input not ready after reset");
   mode_enable_a: assert property (
      !$past(rst) && !$past(rst, 2) && $stable(audio_mode) && audio_mode == $past(audio_mode, 2)
      |-> out_enable == en(audio_mode))
      else $error("output enables do not follow mode");
   mux8_zero_a: assert property (out_valid && out_enable == 8'h00 |-> out_chan == '0)
      else $error("outputs not silent in input mode");
   out_hold_a: assert property (stalled |=> out_valid && $stable(out_chan))
      else $error("output sample changed while stalled");
   peak_level_a: assert property (
      out_valid && out_enable == 8'hff && $stable(peak_headroom)
      |-> peak == pk(out_chan, peak_headroom))
      else $error("peak flags disagree with levels");
   vu_level_a: assert property (
      out_valid && out_enable == 8'hff |-> vu_band == vu(out_chan))
      else $error("vu bands disagree with levels");
   b_off_status_a: assert property (
      out_valid && group_b_off && $past(group_b_off) && $past(group_b_off, 2)
      && $past(group_b_off, 3) |-> group_b_status == emr_pkg::st_off)
      else $error("secondary status not off");
   a_never_off_a: assert property (group_a_status != emr_pkg::st_off)
      else $error("primary status reports off");
endmodule // emr_mixer_router_assertions

bind emr_mixer_router emr_mixer_router_assertions u_chk (.ref_clk, .rst, .in_ready, .audio_mode,
   .group_b_off, .peak_headroom, .out_ready, .out_valid, .out_enable, .out_chan, .peak,
   .vu_band, .group_a_status, .group_b_status);

// ==== sim/emr_far_end.sv ====
module emr_far_end (
   input  wire logic            ref_clk,
   input  wire logic            in_ready,
   output emr_pkg::emr_frame_t  in_frame,
   output logic                 in_valid,
   input  wire logic            out_valid,
   input  wire logic [7:0][23:0] out_chan,
   output logic                 out_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic stall = 1'b0;

   initial
   begin
      in_valid = 1'b0;
      in_frame = '0;
      out_ready = 1'b1;
   end

   // converter side may stall
   always @(posedge ref_clk)
      out_ready <= !stall;

   // whole 16-channel frame held until taken or 40 cycles pass, then scrambled
   task automatic send(input emr_pkg::emr_frame_t f, output logic ok);
      int i;
      @(posedge ref_clk);
      in_valid <= 1'b1;
      in_frame <= f;
      for (i = 0; i < 40; i++)
      begin
         @(posedge ref_clk);
         if (in_ready === 1'b1)
            break;
      end
      ok = i < 40;
      in_valid <= 1'b0;
      in_frame <= ~f;
   endtask

   task automatic recv(output logic [7:0][23:0] c, output logic ok);
      int i;
      for (i = 0; i < 40; i++)
      begin
         @(posedge ref_clk);
         if (out_valid === 1'b1 && out_ready === 1'b1)
            break;
      end
      ok = i < 40;
      c = out_chan;
   endtask
endmodule // emr_far_end

// ==== sim/emr_mixer_router_tb.sv ====
module emr_mixer_router_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic in_valid, in_ready, group_b_off, vol_wr, out_ready, out_valid, ok;
   emr_pkg::emr_frame_t in_frame, f;
   emr_pkg::emr_mode_t audio_mode;
   emr_pkg::emr_status_t group_a_status, group_b_status;
   logic [1:0] group_a_sel, group_b_sel;
   logic [7:0] gain_wr, tie, invert, out_enable, peak;
   logic signed [7:0] gain_wdata;
   logic [7:0][7:0] output_channel_route;
   logic [2:0] peak_headroom, mon_sel, hdmi_sel;
   logic [6:0] vol_wdata;
   logic [7:0][23:0] out_chan, got;
   logic [15:0][23:0] embed_out;
   logic [23:0] mon_left, mon_right, hdmi_left, hdmi_right, t;
   logic [7:0][1:0] vu_band;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n, cnt, v;

   emr_mixer_router u_dut (.ref_clk, .rst, .in_valid, .in_frame, .in_ready, .audio_mode,
      .group_a_sel, .group_b_sel, .group_b_off, .gain_wr, .gain_wdata, .tie, .invert,
      .output_channel_route, .peak_headroom, .mon_sel, .vol_wr, .vol_wdata, .hdmi_sel,
      .out_ready, .out_valid, .out_enable, .out_chan, .embed_out, .mon_left, .mon_right,
      .hdmi_left, .hdmi_right, .peak, .vu_band, .group_a_status, .group_b_status);
   emr_far_end u_far (.ref_clk, .in_ready, .in_frame, .in_valid, .out_valid, .out_chan,
      .out_ready);

   always #25 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic defaults();
      audio_mode <= emr_pkg::mode_demux;
      group_a_sel <= 2'h1;
      group_b_sel <= 2'h2;
      group_b_off <= 1'b0;
      gain_wr <= 8'h00;
      gain_wdata <= 8'sh00;
      tie <= 8'h00;
      invert <= 8'h00;
      for (int i = 0; i < 8; i++)
         output_channel_route[i] <= 8'h01 << i;
      peak_headroom <= 3'h0;
      mon_sel <= 3'h0;
      hdmi_sel <= 3'h0;
      vol_wr <= 1'b0;
      vol_wdata <= 7'h00;
   endtask

   task automatic set_gain(input int i, input logic signed [7:0] db);
      @(posedge ref_clk);
      gain_wr <= 8'h01 << i;
      gain_wdata <= db;
      @(posedge ref_clk);
      gain_wr <= 8'h00;
   endtask

   task automatic run(input emr_pkg::emr_frame_t fr);
      u_far.send(fr, ok);
      chk("frame taken", 1, ok);
      u_far.recv(got, ok);
      chk("frame out", 1, ok);
   endtask

   function automatic emr_pkg::emr_frame_t mk();
      mk.present = 4'hf;
      for (int i = 0; i < 16; i++)
         mk.chan[i] = 24'(i + 1) << 16;
   endfunction

   function automatic logic [23:0] scale(input logic [23:0] s, input int p);
      return 24'((longint'($signed(s)) * p * longint'(emr_pkg::VOL_RECIP)) >>> emr_pkg::VOL_SHIFT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      defaults();
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      f = mk();
      run(f);
      for (int j = 0; j < 8; j++)
         chk("out_chan", f.chan[j + 4], got[j]);
      for (int j = 0; j < 16; j++)
         chk("embed_out", f.chan[j], embed_out[j]);
      chk("status a", emr_pkg::st_group2, group_a_status);
      chk("status b", emr_pkg::st_group3, group_b_status);
      $display("test base done");
      for (int k = 0; k < 8; k++)
      begin
         @(posedge ref_clk);
         mon_sel <= 3'(k);
         hdmi_sel <= 3'(7 - k);
         vol_wr <= (k == 4 || k == 6);
         vol_wdata <= (k == 4) ? 7'h32 : 7'h7f;
         @(posedge ref_clk);
         vol_wr <= 1'b0;
         run(f);
         v = (k == 4 || k == 5) ? 50 : 100;
         chk("mon_left", scale(f.chan[2 * k], v), mon_left);
         chk("mon_right", scale(f.chan[2 * k + 1], v), mon_right);
         chk("hdmi_left", f.chan[14 - 2 * k], hdmi_left);
         chk("hdmi_right", f.chan[15 - 2 * k], hdmi_right);
      end
      $display("test monitor done");
      @(posedge ref_clk);
      invert <= 8'h01;
      tie <= 8'h24;
      output_channel_route[1] <= 8'h03;
      set_gain(1, 8'sd12);
      set_gain(2, 8'sd6);
      set_gain(4, 8'sd6);
      set_gain(7, -8'sd128);
      f.chan[6] = 24'h500000;
      f.chan[7] = 24'hb00000;
      run(f);
      chk("mix0", 24'h130000, got[0]);
      chk("mix1", 24'h180000, got[1]);
      chk("sat hi", emr_pkg::SAMPLE_MAX, got[2]);
      chk("tie lo", emr_pkg::SAMPLE_MIN, got[3]);
      chk("tie a", 24'h120000, got[4]);
      chk("tie b", 24'h140000, got[5]);
      chk("unity", 24'h0b0000, got[6]);
      t = 24'((longint'(f.chan[11]) * longint'(emr_pkg::GAIN_MANT[2])) >>> emr_pkg::GAIN_FRAC);
      chk("min gain", t, got[7]);
      @(posedge ref_clk);
      rst <= 1'b1;
      defaults();
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      f = mk();
      run(f);
      for (int j = 0; j < 8; j++)
         chk("default gain", f.chan[j + 4], got[j]);
      $display("test gain done");
      @(posedge ref_clk);
      group_b_off <= 1'b1;
      f.present = 4'hd;
      run(f);
      chk("status a", emr_pkg::st_no_audio, group_a_status);
      chk("status b", emr_pkg::st_off, group_b_status);
      chk("absent a", 24'h0, got[0]);
      chk("off b", 24'h0, got[4]);
      f = mk();
      for (int m = 0; m < 3; m++)
      begin
         @(posedge ref_clk);
         audio_mode <= emr_pkg::emr_mode_t'(m);
         group_b_off <= 1'b0;
         run(f);
         chk("out_enable", (m == 0) ? emr_pkg::OUT_EN_MUX4 : (m == 1) ? emr_pkg::OUT_EN_MUX8 :
            emr_pkg::OUT_EN_DEMUX, out_enable);
         chk("mode out", (m == 1) ? 24'h0 : f.chan[4], got[0]);
      end
      $display("test modes done");
      for (int h = 0; h < 7; h++)
      begin
         t = emr_pkg::PEAK_THR[(h > 5) ? 0 : h];
         f = mk();
         f.chan[0] = t;
         f.chan[1] = t - 24'h1;
         f.chan[2] = 24'h0cccce;
         f.chan[3] = 24'h020000;
         f.chan[8] = -t;
         f.chan[9] = 24'h000100;
         @(posedge ref_clk);
         group_a_sel <= 2'h0;
         peak_headroom <= 3'(h);
         run(f);
         chk("peak", 24'h11, peak);
         chk("vu_band", 24'h526a, vu_band);
      end
      $display("test meter done");
      @(posedge ref_clk);
      u_far.stall <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         f.chan[0] = 24'(n);
         u_far.send(f, ok);
         if (!ok)
            break;
      end
      @(posedge ref_clk);
      u_far.stall <= 1'b0;
      for (cnt = 0; cnt < n; cnt++)
      begin
         u_far.recv(got, ok);
         if (!ok)
            break;
         chk("fifo order", 24'(cnt), got[0]);
      end
      chk("fifo depth", 24'h1, 24'(cnt == n && n >= 16 && n < 40));
      $display("test fifo done");
      end_sim();
   end
endmodule // emr_mixer_router_tb
